// >>> hw/pioc_defs.svh
// register offsets, field positions, reset values and pin masks of the port cell block
// assumes an APB slave with 32-bit data, one aligned word per register
// How it works
// - reset: digital mode, high-z, pull-up on
// - analog pin: pull-up and receiver off
// - analog pin reads back zero
// - digital pin reads pad level
// - push-pull drives pad from output value
// - open-drain: low drive only, else off
// - undriven digital pin gets weak pull-up
// - pull-up off while driving low
// - global disable kills all pull-ups
// - per-pin drive strength, low at reset
// - eleven usable pins in three ports
// - radio link bits hidden from software
// - top bit of port two shares debug data
`ifndef PIOC_DEFS_SVH
`define PIOC_DEFS_SVH

// per-port register block: port n sits at n * PORT_STRIDE
`define PIOC_OFF_ANALOG_DIGITAL 12'h000
`define PIOC_OFF_OUTPUT_MODE 12'h004
`define PIOC_OFF_DRIVE_STRENGTH 12'h008
`define PIOC_OFF_OUTPUT_VALUE 12'h00C
`define PIOC_OFF_PAD_READ 12'h010
`define PIOC_PORT_STRIDE 12'h020
`define PIOC_OFF_GLOBAL_CTRL 12'h060
`define PIOC_NUM_PORTS 3
`define PIOC_PORT_W 8
// global control field
`define PIOC_GLOBAL_PULLUP_DISABLE_BIT 0
// reset values
`define PIOC_RST_ANALOG_DIGITAL 8'hFF
`define PIOC_RST_OUTPUT_MODE 8'h00
`define PIOC_RST_DRIVE_STRENGTH 8'h00
`define PIOC_RST_OUTPUT_VALUE 8'hFF
`define PIOC_RST_PULLUP_DISABLE 1'b0
// usable pin masks: port0 bits 0-6, port1 bits 4-6, port2 bit 7
`define PIOC_MASK_P0 8'h7F
`define PIOC_MASK_P1 8'h70
`define PIOC_MASK_P2 8'h80

`endif

// >>> hw/pioc_pkg.sv
// types shared by the port cell block
// assumes pioc_defs.svh supplies the numbers
package pioc_pkg;
  typedef logic [7:0] pioc_byte_t;
  typedef enum logic [1:0] {
    PIOC_IDLE = 2'b00,
    PIOC_SETUP = 2'b01,
    PIOC_ACCESS = 2'b11
  } pioc_apb_phase_t;
endpackage : pioc_pkg

// >>> hw/pioc_top.sv
// per-pin configuration and pad control of the general-purpose port, apb slave
// assumes pads resolved outside from drive enable, pull enable and strength
`timescale 1ns/1ps
`include "pioc_defs.svh"

module pioc_top
  import pioc_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads, three byte-wide ports flattened as port*8+bit
  input wire logic [23:0] pad_in,
  output logic [23:0] pad_out,
  output logic [23:0] pad_oe,
  output logic [23:0] pad_pullup_en,
  output logic [23:0] pad_receiver_en,
  output logic [23:0] pad_high_drive,
  // debug data line shares port2 bit 7 pad
  input wire logic debug_port_data_line_active,
  input wire logic debug_port_data_line_out,
  input wire logic debug_port_data_line_oe,
  output logic debug_port_data_line_in
);

  localparam logic [23:0] USABLE = {`PIOC_MASK_P2, `PIOC_MASK_P1, `PIOC_MASK_P0};

  pioc_byte_t pin_analog_digital_select_r [`PIOC_NUM_PORTS];
  pioc_byte_t pin_output_mode_select_r [`PIOC_NUM_PORTS];
  pioc_byte_t pin_drive_strength_select_r [`PIOC_NUM_PORTS];
  pioc_byte_t out_value_r [`PIOC_NUM_PORTS];
  logic global_pullup_disable_r;

  // decode
  logic wr_en, rd_en, hit;
  logic [1:0] port_idx;
  logic [4:0] reg_off;
  logic [31:0] rdata_nxt;
  // a write lands only at the edge where the master samples pready high
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  assign port_idx = paddr[6:5];
  assign reg_off = paddr[4:0];

  // read mux; reserved and radio-link bits read zero
  always_comb begin
    logic [7:0] m;
    m = 8'h00;
    hit = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (paddr == `PIOC_OFF_GLOBAL_CTRL) begin
      hit = 1'b1;
      rdata_nxt[`PIOC_GLOBAL_PULLUP_DISABLE_BIT] = global_pullup_disable_r;
    end else if (port_idx < 2'd3 && paddr[11:7] == 5'h00) begin
      m = USABLE[port_idx*8 +: 8];
      hit = 1'b1;
      unique case ({7'h00, reg_off})
        `PIOC_OFF_ANALOG_DIGITAL: rdata_nxt[7:0] = pin_analog_digital_select_r[port_idx] & m;
        `PIOC_OFF_OUTPUT_MODE: rdata_nxt[7:0] = pin_output_mode_select_r[port_idx] & m;
        `PIOC_OFF_DRIVE_STRENGTH: rdata_nxt[7:0] = pin_drive_strength_select_r[port_idx] & m;
        `PIOC_OFF_OUTPUT_VALUE: rdata_nxt[7:0] = out_value_r[port_idx] & m;
        // analog pins read 0, digital pins read pad level
        `PIOC_OFF_PAD_READ: rdata_nxt[7:0] =
          pad_in[port_idx*8 +: 8] & pin_analog_digital_select_r[port_idx] & m;
        default: hit = 1'b0;
      endcase
    end
  end

  // apb response: one wait state, answer in the access cycle's second edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd_en) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // per-port configuration bytes, bit n controls pin n; byte lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < `PIOC_NUM_PORTS; p++) begin
        pin_analog_digital_select_r[p] <= `PIOC_RST_ANALOG_DIGITAL;
        pin_output_mode_select_r[p] <= `PIOC_RST_OUTPUT_MODE;
        pin_drive_strength_select_r[p] <= `PIOC_RST_DRIVE_STRENGTH;
        out_value_r[p] <= `PIOC_RST_OUTPUT_VALUE;
      end
    end else if (wr_en && hit && pstrb[0] && paddr != `PIOC_OFF_GLOBAL_CTRL) begin
      unique case ({7'h00, reg_off})
        `PIOC_OFF_ANALOG_DIGITAL: pin_analog_digital_select_r[port_idx] <= pwdata[7:0];
        `PIOC_OFF_OUTPUT_MODE: pin_output_mode_select_r[port_idx] <= pwdata[7:0];
        `PIOC_OFF_DRIVE_STRENGTH: pin_drive_strength_select_r[port_idx] <= pwdata[7:0];
        `PIOC_OFF_OUTPUT_VALUE: out_value_r[port_idx] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // global pull-up disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_pullup_disable_r <= `PIOC_RST_PULLUP_DISABLE;
    end else if (wr_en && pstrb[0] && paddr == `PIOC_OFF_GLOBAL_CTRL) begin
      global_pullup_disable_r <= pwdata[`PIOC_GLOBAL_PULLUP_DISABLE_BIT];
    end
  end

  // pad cell control, registered so every output comes from a flip-flop
  logic [23:0] dig, val, pp, oe_n, out_n, pu_n;
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      dig[i] = pin_analog_digital_select_r[i/8][i%8];
      val[i] = out_value_r[i/8][i%8];
      pp[i] = pin_output_mode_select_r[i/8][i%8];
      oe_n[i] = USABLE[i] && (pp[i] || !val[i]);
      out_n[i] = pp[i] ? val[i] : 1'b0;
    end
    // debug line owns the shared pad while active
    if (debug_port_data_line_active) begin
      oe_n[23] = debug_port_data_line_oe;
      out_n[23] = debug_port_data_line_out;
    end
    for (int i = 0; i < 24; i++) begin
      // pull-up only on digital, undriven or driven-high pins
      pu_n[i] = USABLE[i] && dig[i] && !global_pullup_disable_r
                && !(oe_n[i] && !out_n[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 24'hFFFFFF;
      pad_oe <= 24'h000000;
      pad_pullup_en <= USABLE;
      pad_receiver_en <= USABLE;
      pad_high_drive <= 24'h000000;
      debug_port_data_line_in <= 1'b0;
    end else begin
      pad_out <= out_n;
      pad_oe <= oe_n;
      pad_pullup_en <= pu_n;
      pad_receiver_en <= dig & USABLE;
      pad_high_drive <= {pin_drive_strength_select_r[2], pin_drive_strength_select_r[1],
                         pin_drive_strength_select_r[0]} & USABLE;
      debug_port_data_line_in <= pad_in[23];
    end
  end

endmodule : pioc_top

// >>> sim/pioc_pads.sv
// board-side model of the port pads
// assumes the testbench adds its own drive through ext_en and ext_val
`timescale 1ns/1ps
module pioc_pads (
  // clock for the float pattern
  input wire logic pclk,
  // device side
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe,
  input wire logic [23:0] pad_pullup_en,
  // board drive
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pad_in
);
  logic [23:0] last_r;
  // a floating pad must not look stable, so it flips each cycle
  always_ff @(posedge pclk) last_r <= pad_in;
  // drivers first, then board, then weak pull-up
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = ~last_r[i];
    end
  end
endmodule : pioc_pads

// >>> sim/pioc_top_checker.sv
// assertions on the port cell block ports
// assumes one clock and an async low reset
`timescale 1ns/1ps
module pioc_top_checker (
  // apb
  input wire logic pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [31:0] prdata,
  // pads
  input wire logic [23:0] pad_in, pad_out, pad_oe, pad_pullup_en,
  input wire logic [23:0] pad_receiver_en, pad_high_drive,
  input wire logic debug_port_data_line_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_pair: assert property (pslverr |-> pready) else $error("lone error");
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
  a_reset_pads: assert property ($rose(presetn) |-> pad_oe == 24'h0 && pad_high_drive == 24'h0
    && pad_pullup_en == 24'h80707F) else $error("reset pads");
  a_analog_pull: assert property ((pad_pullup_en & ~pad_receiver_en) == 24'h0) else $error("pu");
  a_radio_off: assert property (((pad_oe | pad_pullup_en | pad_high_drive) & ~24'h80707F) == 24'h0)
    else $error("radio bit");
  a_low_no_pull: assert property ((pad_oe & ~pad_out & pad_pullup_en) == 24'h0) else $error("lp");
  a_debug_copy: assert property (1 |=> debug_port_data_line_in == $past(pad_in[23]))
    else $error("debug copy");
endmodule : pioc_top_checker
bind pioc_top pioc_top_checker u_chk (.*);

// >>> sim/testbench.sv
// self-checking apb bench for the port cell block
// assumes pioc_top, pioc_pads and the checker bind
`timescale 1ns/1ps
`include "pioc_defs.svh"
module testbench;
  localparam logic [11:0] AD = `PIOC_OFF_ANALOG_DIGITAL, OM = `PIOC_OFF_OUTPUT_MODE;
  localparam logic [11:0] DS = `PIOC_OFF_DRIVE_STRENGTH, OV = `PIOC_OFF_OUTPUT_VALUE;
  localparam logic [11:0] PR = `PIOC_OFF_PAD_READ, GC = `PIOC_OFF_GLOBAL_CTRL;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, dbg;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [23:0] pad_in, pad_out, pad_oe, pu, rx, hd, ext_en = '0, ext_val = '0;
  logic [7:0] msk [3] = '{8'h7F, 8'h70, 8'h80};
  int num_errors = 0, n_checks = 0;
  always #10 pclk = ~pclk;
  // debug path held idle, all four byte strobes held on
  pioc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pu), .pad_receiver_en(rx), .pad_high_drive(hd),
    .debug_port_data_line_active(1'b0), .debug_port_data_line_out(1'b0),
    .debug_port_data_line_oe(1'b0), .debug_port_data_line_in(dbg));
  pioc_pads pads (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pu),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    if (pready !== 1'b1) begin num_errors++; results(); end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    chk(q, {24'h0, e});
  endtask : rd
  // pads lag the register by one cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask : wr
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rd(AD + 12'(p * 32), msk[p]);
      rd(OM + 12'(p * 32), 8'h0);
      rd(DS + 12'(p * 32), 8'h0);
    end
    chk({8'h0, pad_oe | hd}, 32'h0);
    chk({8'h0, pu}, 32'h80707F);
    rd(GC, 8'h0);
    apb(1'b0, 12'h0FC, 8'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("reset test done");
    wr(OM, 8'h7F);
    wr(OV, 8'h55);
    chk(pad_oe[7:0], 8'h7F);
    rd(PR, 8'h55);
    chk(pu[7:0], 8'h55);
    wr(OM, 8'h00);
    wr(OV, 8'h0F);
    chk(pad_oe[7:0], 8'h70);
    rd(PR, 8'h0F);
    ext_en <= 24'h7F;
    wr(OV, 8'hFF);
    rd(PR, 8'h00);
    ext_val <= 24'h7F;
    wr(AD, 8'h0F);
    rd(PR, 8'h0F);
    chk({rx[7:0], pu[7:0]}, 16'h0F0F);
    wr(GC, 8'h01);
    chk(pu, 24'h0);
    wr(GC, 8'h00);
    $display("pin mode test done");
    wr(DS + 12'h020, 8'hFF);
    chk(hd[15:8], 8'h70);
    rd(DS + 12'h020, 8'h70);
    wr(OM + 12'h040, 8'h80);
    rd(PR + 12'h040, 8'h80);
    chk(dbg, 1'b1);
    $display("port test done");
    results();
  end
endmodule : testbench
